// ### shared/pmt_pkg.sv
/*
 * constants, modes and states of the multimode timer.
 * assumes a single 25 MHz system clock and a millisecond time base.
 */
package pmt_pkg;

    // ------------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ    = 25_000_000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

    // ------------------------------------------------------------------
    // widths, trigger positions and reset values
    // ------------------------------------------------------------------
    localparam int          ELAPSED_W     = 32;
    localparam int          NUM_TRIG      = 4;
    localparam int          NUM_EDGE      = 5;
    localparam int          TRG_PULSE     = 0;
    localparam int          TRG_ON_DLY    = 1;
    localparam int          TRG_OFF_DLY   = 2;
    localparam int          TRG_LIMIT     = 3;
    localparam int          EDGE_CLEAR    = 4;
    localparam logic [31:0] ELAPSED_RST   = 32'h0;
    localparam logic [31:0] ELAPSED_STEP  = 32'h1;
    localparam logic        STATUS_RST    = 1'h0;
    localparam logic        GATE_DEFAULT  = 1'h1;
    localparam logic        CLEAR_DEFAULT = 1'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMT_PULSE,
        PMT_ON_DLY,
        PMT_OFF_DLY,
        PMT_LIMIT
    } pmt_mode_t;

    typedef enum logic [1:0] {
        PMT_IDLE,
        PMT_RUN,
        PMT_ARMED,
        PMT_HOLD
    } pmt_state_t;

endpackage

// ### shared/pmt_ev_if.sv
/*
 * carrier between the timer core and its edge detector.
 * assumes all signals are synchronous to the one system clock.
 */
interface pmt_ev_if #(
    parameter int N = 5
);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    modport det (
        input  lvl,
        output rise,
        output fall
    );

    modport use_side (
        output lvl,
        input  rise,
        input  fall
    );
endinterface

// ### src/pmt_edge.sv
/*
 * per-bit rise and fall detector on sampled levels.
 * assumes levels are already synchronous to clk.
 */
module pmt_edge #(
    parameter int N = 5
) (
    input  wire logic clk,
    input  wire logic rst_n,
    pmt_ev_if.det     ev
);

    // ------------------------------------------------------------------
    // previous-sample compare, one flop per input
    // ------------------------------------------------------------------
    logic [N-1:0] prev_r;
    logic [N-1:0] prev_nxt;

    generate
        if (N < 1) begin : g_chk
            $error("pmt_edge: N must be at least 1");
        end
        for (genvar i = 0; i < N; i++) begin : g_bit
            always_comb begin
                prev_nxt[i] = ev.lvl[i];
                ev.rise[i]  = ev.lvl[i] & ~prev_r[i];
                ev.fall[i]  = ~ev.lvl[i] & prev_r[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

endmodule

// ### src/pmt_tick.sv
/*
 * millisecond tick divider, one-cycle enable pulse.
 * assumes restart is a one-cycle pulse when the timer starts counting.
 */
module pmt_tick #(
    parameter int TICK_CYCLES = pmt_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      tick
);

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    generate
        if (TICK_CYCLES < 1) begin : g_chk
            $error("pmt_tick: TICK_CYCLES must be at least 1");
        end
    endgenerate

    // restart realigns the phase so the first millisecond is a full one
    always_comb begin
        tick_nxt = 1'h0;
        cnt_nxt  = cnt_r + CW'(1);
        if (restart) begin
            cnt_nxt = '0;
        end else if (cnt_r == LAST) begin
            cnt_nxt  = '0;
            tick_nxt = 1'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            tick_r <= 1'h0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

// ### src/pmt_timer.sv
/*
 * programmable multimode timer: pulse, on-delay, off-delay and limiting.
 * assumes all inputs synchronous to clk; controller reads status and
 * elapsed time directly from the output ports.
 */
// Overview of operation
// - gate low freezes elapsed count after trigger; gate high resumes counting.
// - gate defaults to 1 whenever the controller does not drive it.
// - clear defaults to 0 whenever the controller does not drive it.
// - clear rising edge zeroes status and elapsed and deactivates timer.
// - four trigger inputs select pulse, on-delay, off-delay, limiting modes.
// - time constant captured with trigger, any value up to 2^32-1 ms.
// - status bit and elapsed-time word are both readable outputs.
// - pulse rising edge sets status 1, elapsed restarts at 0.
// - pulse expiry drops status to 0 and holds elapsed time.
// - pulse trigger edges ignored while timing; only rise after expiry restarts.
// - on-delay rise restarts count; expiry sets status until trigger falls.
// - on-delay fall before expiry stops timing, status 0, elapsed kept.
// - on-delay elapsed held until next rising edge on any trigger input.
// - off-delay rise sets status 1; counting starts from 0 on fall.
// - off-delay expiry stops count, status 0, elapsed held until rise.
// - off-delay rise before expiry retriggers: status 1, elapsed 0.
// - limiting rise sets status 1, counts from 0; expiry drops status.
// - limiting fall before expiry stops count, status 0, elapsed kept.
// - limiting elapsed held until a new rising edge restarts it.
// - reset brings status and elapsed count to 0.
module pmt_timer #(
    parameter int TICK_CYCLES = pmt_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        gate_input,
    input  wire logic        gate_drive,
    input  wire logic        clear_input,
    input  wire logic        clear_drive,
    input  wire logic        pulse_trigger,
    input  wire logic        on_delay_trigger,
    input  wire logic        off_delay_trigger,
    input  wire logic        limit_trigger,
    input  wire logic [31:0] time_const,
    output logic             status_out,
    output logic [31:0]      elapsed_time,
    output logic             timer_active
);

    // ------------------------------------------------------------------
    // input defaults and edge detection
    // ------------------------------------------------------------------
    logic gate_eff;
    logic clr_eff;
    logic clr_rise;
    logic any_rise;
    logic tick;
    logic restart;

    pmt_ev_if #(.N(pmt_pkg::NUM_EDGE)) ev ();

    // undriven gate reads as running, undriven clear as inactive
    assign gate_eff = gate_drive ? gate_input : pmt_pkg::GATE_DEFAULT;
    assign clr_eff  = clear_drive ? clear_input
                                  : pmt_pkg::CLEAR_DEFAULT;

    assign ev.lvl = {clr_eff, limit_trigger, off_delay_trigger,
                     on_delay_trigger, pulse_trigger};

    pmt_edge #(
        .N (pmt_pkg::NUM_EDGE)
    ) u_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .ev    (ev)
    );

    assign clr_rise = ev.rise[pmt_pkg::EDGE_CLEAR];
    assign any_rise = |ev.rise[pmt_pkg::NUM_TRIG-1:0];

    pmt_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (restart),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // timer state
    // ------------------------------------------------------------------
    pmt_pkg::pmt_state_t state_r;
    pmt_pkg::pmt_state_t state_nxt;
    pmt_pkg::pmt_mode_t  mode_r;
    pmt_pkg::pmt_mode_t  mode_nxt;
    logic                status_r;
    logic                status_nxt;
    logic [31:0]         elapsed_r;
    logic [31:0]         elapsed_nxt;
    logic [31:0]         tconst_r;
    logic [31:0]         tconst_nxt;
    logic                restart_nxt;
    logic                pulse_busy;
    logic                own_fall;
    logic                expired;
    pmt_pkg::pmt_mode_t  sel_mode;

    assign pulse_busy = (state_r == pmt_pkg::PMT_RUN)
                      && (mode_r == pmt_pkg::PMT_PULSE);
    assign own_fall   = ev.fall[mode_r];
    assign expired    = (elapsed_r == tconst_r);
    assign restart    = restart_nxt;

    // lowest trigger number wins when several rise together
    always_comb begin
        sel_mode = pmt_pkg::PMT_LIMIT;
        for (int i = pmt_pkg::NUM_TRIG - 1; i >= 0; i--) begin
            if (ev.rise[i]) begin
                sel_mode = pmt_pkg::pmt_mode_t'(i[1:0]);
            end
        end
    end

    always_comb begin
        state_nxt   = state_r;
        mode_nxt    = mode_r;
        status_nxt  = status_r;
        elapsed_nxt = elapsed_r;
        tconst_nxt  = tconst_r;
        restart_nxt = 1'h0;
        if (clr_rise) begin
            // clear outranks a trigger arriving in the same cycle
            state_nxt   = pmt_pkg::PMT_IDLE;
            status_nxt  = pmt_pkg::STATUS_RST;
            elapsed_nxt = pmt_pkg::ELAPSED_RST;
        end else if (any_rise && !pulse_busy) begin
            mode_nxt    = sel_mode;
            tconst_nxt  = time_const;
            elapsed_nxt = pmt_pkg::ELAPSED_RST;
            restart_nxt = 1'h1;
            case (sel_mode)
                pmt_pkg::PMT_PULSE: begin
                    state_nxt  = pmt_pkg::PMT_RUN;
                    status_nxt = 1'h1;
                end
                pmt_pkg::PMT_ON_DLY: begin
                    state_nxt  = pmt_pkg::PMT_RUN;
                    status_nxt = 1'h0;
                end
                pmt_pkg::PMT_OFF_DLY: begin
                    state_nxt  = pmt_pkg::PMT_ARMED;
                    status_nxt = 1'h1;
                end
                default: begin
                    state_nxt  = pmt_pkg::PMT_RUN;
                    status_nxt = 1'h1;
                end
            endcase
        end else begin
            case (state_r)
                pmt_pkg::PMT_RUN: begin
                    if (own_fall && (mode_r == pmt_pkg::PMT_ON_DLY
                                  || mode_r == pmt_pkg::PMT_LIMIT)) begin
                        state_nxt  = pmt_pkg::PMT_IDLE;
                        status_nxt = 1'h0;
                    end else if (expired) begin
                        if (mode_r == pmt_pkg::PMT_ON_DLY) begin
                            state_nxt  = pmt_pkg::PMT_HOLD;
                            status_nxt = 1'h1;
                        end else begin
                            state_nxt  = pmt_pkg::PMT_IDLE;
                            status_nxt = 1'h0;
                        end
                    end else if (tick && gate_eff) begin
                        elapsed_nxt = elapsed_r + pmt_pkg::ELAPSED_STEP;
                    end
                end
                pmt_pkg::PMT_ARMED: begin
                    if (ev.fall[pmt_pkg::TRG_OFF_DLY]) begin
                        state_nxt   = pmt_pkg::PMT_RUN;
                        elapsed_nxt = pmt_pkg::ELAPSED_RST;
                        restart_nxt = 1'h1;
                    end
                end
                pmt_pkg::PMT_HOLD: begin
                    if (ev.fall[pmt_pkg::TRG_ON_DLY]) begin
                        state_nxt  = pmt_pkg::PMT_IDLE;
                        status_nxt = 1'h0;
                    end
                end
                default: begin
                    // idle keeps the last elapsed value for reading
                    state_nxt = pmt_pkg::PMT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= pmt_pkg::PMT_IDLE;
            mode_r    <= pmt_pkg::PMT_PULSE;
            status_r  <= pmt_pkg::STATUS_RST;
            elapsed_r <= pmt_pkg::ELAPSED_RST;
            tconst_r  <= pmt_pkg::ELAPSED_RST;
        end else begin
            state_r   <= state_nxt;
            mode_r    <= mode_nxt;
            status_r  <= status_nxt;
            elapsed_r <= elapsed_nxt;
            tconst_r  <= tconst_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign status_out   = status_r;
    assign elapsed_time = elapsed_r;
    assign timer_active = (state_r != pmt_pkg::PMT_IDLE);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_quiet;
        !clr_rise && !any_rise;
    endsequence

    sequence s_run_mode(pmt_pkg::pmt_mode_t m);
        state_r == pmt_pkg::PMT_RUN && mode_r == m;
    endsequence

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        clr_rise |=> !status_r && elapsed_r == 32'h0 && !timer_active;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear edge did not reset the timer");

    property p_gate_freeze;
        @(posedge clk) disable iff (!rst_n)
        (!gate_eff && !clr_rise && !any_rise) |=> $stable(elapsed_r);
    endproperty
    a_gate_freeze: assert property (p_gate_freeze)
        else $error("elapsed time moved with gate low");

    property p_count;
        @(posedge clk) disable iff (!rst_n)
        (state_r == pmt_pkg::PMT_RUN && gate_eff && tick && !expired
         && !own_fall && !clr_rise && !any_rise)
        |=> elapsed_r == $past(elapsed_r) + 32'h1;
    endproperty
    a_count: assert property (p_count)
        else $error("elapsed time did not advance on tick");

    property p_pulse_start;
        @(posedge clk) disable iff (!rst_n)
        (state_r == pmt_pkg::PMT_IDLE && ev.rise[0] && !clr_rise)
        |=> status_r && elapsed_r == 32'h0
            ##1 (status_r || $past(expired) || $past(clr_rise));
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("pulse trigger did not start timing");

    property p_pulse_ignore;
        @(posedge clk) disable iff (!rst_n)
        (s_run_mode(pmt_pkg::PMT_PULSE) ##0 !expired && !clr_rise)
        |=> state_r == pmt_pkg::PMT_RUN && status_r;
    endproperty
    a_pulse_ignore: assert property (p_pulse_ignore)
        else $error("pulse timing disturbed by trigger");

    property p_pulse_end;
        @(posedge clk) disable iff (!rst_n)
        (s_run_mode(pmt_pkg::PMT_PULSE) ##0 expired && !clr_rise)
        |=> !status_r && $stable(elapsed_r);
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("pulse expiry wrong");

    property p_on_expire;
        @(posedge clk) disable iff (!rst_n)
        (s_run_mode(pmt_pkg::PMT_ON_DLY) ##0 expired && !own_fall
         ##0 s_quiet)
        |=> status_r ##1 (status_r || $past(ev.fall[pmt_pkg::TRG_ON_DLY])
                          || $past(clr_rise) || $past(any_rise));
    endproperty
    a_on_expire: assert property (p_on_expire)
        else $error("on-delay expiry did not raise status");

    property p_early_fall;
        @(posedge clk) disable iff (!rst_n)
        (state_r == pmt_pkg::PMT_RUN && own_fall && !clr_rise && !any_rise
         && (mode_r == pmt_pkg::PMT_ON_DLY || mode_r == pmt_pkg::PMT_LIMIT))
        |=> !status_r && $stable(elapsed_r) && !timer_active;
    endproperty
    a_early_fall: assert property (p_early_fall)
        else $error("early trigger fall handled wrongly");

    property p_off_arm;
        @(posedge clk) disable iff (!rst_n)
        (ev.rise[2] && !ev.rise[0] && !ev.rise[1] && !clr_rise
         && !pulse_busy)
        |=> status_r && elapsed_r == 32'h0
            && state_r == pmt_pkg::PMT_ARMED;
    endproperty
    a_off_arm: assert property (p_off_arm)
        else $error("off-delay trigger did not arm");

    property p_idle_hold;
        @(posedge clk) disable iff (!rst_n)
        (state_r == pmt_pkg::PMT_IDLE && !clr_rise && !any_rise)
        |=> $stable(elapsed_r) && $stable(status_r);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle timer changed its outputs");

endmodule

// ### tb/pmt_timer_tb_top.sv
/*
 * self-checking bench for the multimode timer, one task per scenario.
 * assumes the timer core is built with a 4-cycle millisecond tick.
 */
module pmt_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int TCK = 4;

    logic        clk;
    logic        rst_n;
    logic        gate_input;
    logic        gate_drive;
    logic        clear_input;
    logic        clear_drive;
    logic        pulse_trigger;
    logic        on_delay_trigger;
    logic        off_delay_trigger;
    logic        limit_trigger;
    logic [31:0] time_const;
    logic        status_out;
    logic [31:0] elapsed_time;
    logic        timer_active;
    int          n_mismatch;
    int          checked;

    pmt_timer #(
        .TICK_CYCLES (TCK)
    ) i_pmt_timer (
        .clk               (clk),
        .rst_n             (rst_n),
        .gate_input        (gate_input),
        .gate_drive        (gate_drive),
        .clear_input       (clear_input),
        .clear_drive       (clear_drive),
        .pulse_trigger     (pulse_trigger),
        .on_delay_trigger  (on_delay_trigger),
        .off_delay_trigger (off_delay_trigger),
        .limit_trigger     (limit_trigger),
        .time_const        (time_const),
        .status_out        (status_out),
        .elapsed_time      (elapsed_time),
        .timer_active      (timer_active)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // inputs always move 2 ns after the edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk1(input logic got, input logic exp, input string w);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, w, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                         input string w);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, w, got,
                     exp);
        end
    endtask

    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bounded wait on status (on_el=0) or on elapsed time (on_el=1)
    task automatic wait_for(input bit on_el, input logic [31:0] v,
                            input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            if (on_el ? (elapsed_time === v) : (status_out === v[0])) begin
                break;
            end
            step(1);
        end
        if (i == bound) begin
            n_mismatch++;
            $display("CHECK FAILED %0t wait ran out", $time);
            results();
        end
    endtask

    task automatic do_clear;
        clear_input = 1'h1;
        step(2);
        clear_input = 1'h0;
        step(1);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk1(status_out, 1'h0, "reset status");
        chk32(elapsed_time, 32'h0, "reset elapsed");
        chk1(timer_active, 1'h0, "reset active");
    endtask

    task automatic t_pulse;
        time_const = 32'h4;
        pulse_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h1, "pulse set");
        chk32(elapsed_time, 32'h0, "pulse start");
        wait_for(1'b1, 32'h2, 40);
        // both edges land inside the same millisecond as the check
        pulse_trigger = 1'h0;
        step(1);
        pulse_trigger = 1'h1;
        step(1);
        chk32(elapsed_time, 32'h2, "pulse edges ignored");
        chk1(status_out, 1'h1, "pulse still on");
        wait_for(1'b0, 32'h0, 40);
        chk32(elapsed_time, 32'h4, "pulse expiry");
        step(12);
        chk32(elapsed_time, 32'h4, "pulse held");
        chk1(timer_active, 1'h0, "pulse idle");
        pulse_trigger = 1'h0;
        step(2);
        pulse_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h1, "pulse again");
        chk32(elapsed_time, 32'h0, "pulse again t");
    endtask

    task automatic t_clear;
        // pulse from t_pulse still running; undriven clear reads low
        wait_for(1'b1, 32'h1, 40);
        clear_drive = 1'h0;
        clear_input = 1'h1;
        step(3);
        chk1(status_out, 1'h1, "undriven clear");
        clear_input = 1'h0;
        step(1);
        clear_drive = 1'h1;
        step(1);
        do_clear();
        chk1(status_out, 1'h0, "clear status");
        chk32(elapsed_time, 32'h0, "clear elapsed");
        chk1(timer_active, 1'h0, "clear active");
        step(12);
        chk32(elapsed_time, 32'h0, "stays cleared");
        pulse_trigger = 1'h0;
        step(1);
    endtask

    task automatic t_gate;
        time_const = 32'h5;
        gate_drive = 1'h0;
        gate_input = 1'h0;
        pulse_trigger = 1'h1;
        wait_for(1'b1, 32'h1, 40);
        gate_drive = 1'h1;
        step(20);
        chk32(elapsed_time, 32'h1, "gate frozen");
        chk1(status_out, 1'h1, "gate frozen st");
        gate_input = 1'h1;
        wait_for(1'b0, 32'h0, 60);
        chk32(elapsed_time, 32'h5, "gate resumed");
        pulse_trigger = 1'h0;
        gate_drive = 1'h0;
        step(1);
    endtask

    task automatic t_on_delay;
        time_const = 32'h2;
        on_delay_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h0, "on start st");
        chk32(elapsed_time, 32'h0, "on start t");
        wait_for(1'b0, 32'h1, 40);
        chk32(elapsed_time, 32'h2, "on expiry");
        step(10);
        chk1(status_out, 1'h1, "on held");
        on_delay_trigger = 1'h0;
        step(2);
        chk1(status_out, 1'h0, "on fall");
        step(8);
        chk32(elapsed_time, 32'h2, "on t held");
        on_delay_trigger = 1'h1;
        step(2);
        chk32(elapsed_time, 32'h0, "on restart");
        wait_for(1'b1, 32'h1, 40);
        on_delay_trigger = 1'h0;
        step(12);
        chk1(status_out, 1'h0, "on abort st");
        chk32(elapsed_time, 32'h1, "on abort t");
    endtask

    task automatic t_off_delay;
        time_const = 32'h2;
        off_delay_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h1, "off set");
        step(12);
        chk32(elapsed_time, 32'h0, "off waits");
        off_delay_trigger = 1'h0;
        wait_for(1'b1, 32'h1, 40);
        chk1(status_out, 1'h1, "off counting");
        off_delay_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h1, "off retrigger st");
        chk32(elapsed_time, 32'h0, "off retrigger t");
        off_delay_trigger = 1'h0;
        wait_for(1'b0, 32'h0, 40);
        chk32(elapsed_time, 32'h2, "off expiry");
        step(12);
        chk32(elapsed_time, 32'h2, "off held");
    endtask

    task automatic t_limit;
        time_const = 32'h3;
        limit_trigger = 1'h1;
        step(2);
        chk1(status_out, 1'h1, "lim set");
        chk32(elapsed_time, 32'h0, "lim start");
        wait_for(1'b0, 32'h0, 40);
        chk32(elapsed_time, 32'h3, "lim expiry");
        step(8);
        chk32(elapsed_time, 32'h3, "lim held");
        limit_trigger = 1'h0;
        step(2);
        limit_trigger = 1'h1;
        wait_for(1'b1, 32'h1, 40);
        limit_trigger = 1'h0;
        step(2);
        chk1(status_out, 1'h0, "lim fall st");
        step(10);
        chk32(elapsed_time, 32'h1, "lim fall t");
    endtask

    // extreme time constants: zero expires at once, all-ones never here
    task automatic t_bounds;
        time_const = 32'h0;
        pulse_trigger = 1'h1;
        step(4);
        chk1(status_out, 1'h0, "zero const st");
        chk32(elapsed_time, 32'h0, "zero const t");
        time_const = 32'hffffffff;
        limit_trigger = 1'h1;
        step(40);
        chk1(status_out, 1'h1, "max const st");
        chk1(timer_active, 1'h1, "max const act");
        do_clear();
        chk1(status_out, 1'h0, "max cleared");
        pulse_trigger = 1'h0;
        limit_trigger = 1'h0;
    endtask

    // ------------------------------------------------------------------
    // clock, reset and sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_n = 1'h0;
        gate_input = 1'h1;
        gate_drive = 1'h0;
        clear_input = 1'h0;
        clear_drive = 1'h1;
        pulse_trigger = 1'h0;
        on_delay_trigger = 1'h0;
        off_delay_trigger = 1'h0;
        limit_trigger = 1'h0;
        time_const = 32'h0;
        step(3);
        rst_n = 1'h1;
        step(1);
        t_reset();
        t_pulse();
        t_clear();
        t_gate();
        t_on_delay();
        t_off_delay();
        t_limit();
        t_bounds();
        results();
    end
endmodule
